//--- include/rtv_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the rail target block
// Assumes: byte-wide register port, 125 MHz sys_clk
// Notes: definitions only
`ifndef RTV_REGS_SVH
`define RTV_REGS_SVH

// page that holds this rail's registers
`define RTV_PAGE_RAIL 8'h03

// register offsets inside the page
`define RTV_ADDR_GAIN3 8'h76
`define RTV_ADDR_GAIN4 8'h77
`define RTV_ADDR_OFFSET 8'h80
`define RTV_ADDR_FIX_EN 8'h81
`define RTV_ADDR_FIX_LO 8'h82
`define RTV_ADDR_FIX_HI 8'h83

// field positions
`define RTV_GAIN_MSB 2
`define RTV_FIX_EN_BIT 0
`define RTV_FIX_HI_BIT 0
`define RTV_OFFSET_SIGN_BIT 7

// fixed reset values (gains and offset come from configuration storage)
`define RTV_RST_GAIN 3'h4
`define RTV_RST_FIX_EN 1'b0
`define RTV_RST_FIX_LO 8'h83
`define RTV_RST_FIX_HI 1'b0

// target code limits, code zero means output off
`define RTV_CODE_OFF 9'h000
`define RTV_CODE_MIN 9'h001
`define RTV_CODE_MAX 9'h1ff

// timing: one code step is 5 mV, slowest allowed ramp is 2.5 mV/us
`define RTV_CLK_PERIOD_NS 8
`define RTV_STEP_UV 5000
`define RTV_MIN_SLEW_UV_PER_US 2500
`define RTV_SLEW_DIVISOR 4
// longest step time rounds down to whole cycles
`define RTV_MAX_STEP_CYC ((`RTV_STEP_UV * 1000 / `RTV_MIN_SLEW_UV_PER_US) / `RTV_CLK_PERIOD_NS)

`endif

//--- include/rtv_pkg.sv
// Purpose: types shared by the rail target block
// Assumes: nothing beyond the register header
// Notes: power states follow the processor's two-bit encoding
package rtv_pkg;

    // power state, full power is code zero
    typedef enum logic [1:0] {
        RTV_PS_FULL = 2'h0,
        RTV_PS_ONE = 2'h1,
        RTV_PS_TWO = 2'h2,
        RTV_PS_THREE = 2'h3
    } rtv_psi_t;

    // commands arriving from the processor voltage link decoder
    typedef struct packed {
        logic tgt_valid;
        logic [8:0] tgt_code;
        logic off_valid;
        logic psi_valid;
        rtv_psi_t psi;
    } rtv_proc_cmd_t;

    // what the regulation loop receives
    typedef struct packed {
        logic [8:0] target_code;
        logic target_off;
        rtv_psi_t psi;
        logic ramping;
        logic fixed_active;
    } rtv_loop_t;

endpackage

//--- logic/rtv_ramp.sv
// Purpose: walk the target code toward its goal one code per step enable
// Assumes: step_en is a one-cycle pulse from the slew divider
// Notes: jump loads the goal at once, used for processor driven moves
`timescale 1ns/1ns
module rtv_ramp (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic [8:0] goal,
    input wire logic jump,
    input wire logic step_en,
    // state
    output logic [8:0] cur_r,
    output logic busy
);
    // one code per step, the loop never sees a bigger slow move
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_r <= 9'h000;
        end else if (jump) begin
            cur_r <= goal;
        end else if (step_en && cur_r < goal) begin
            cur_r <= cur_r + 9'h001;
        end else if (step_en && cur_r > goal) begin
            cur_r <= cur_r - 9'h001;
        end
    end

    assign busy = (cur_r != goal);
endmodule

//--- logic/rtv_regs_top.sv
// Purpose: rail target registers, fixed target mode, host offset and slewed target
// Assumes: register port decoded from the serial host port, page number supplied alongside
// Notes: processor link and analog loop sit outside; tolerance input is asynchronous
`timescale 1ns/1ns
`include "rtv_regs.svh"

// Contract
// - gain fields are three bits, eight gain codes, unity code 100, reset value from configuration storage
// - phase four gain register same coding, upper five bits reserved read-only
// - gain and offset reset values come from configuration storage inputs
// - host offset is signed eight-bit, one target code step per count
// - offset ramps at quarter upward slew, never slower than 2.5 mV/us
// - offset write starts ramp and forces full power during it
// - after ramp done and in tolerance, earlier power state returns
// - processor power state command obeyed during offset, offset stays applied
// - processor off command drives target to zero regardless of offset
// - fixed enable bit zero switches fixed mode, other bits reserved, reset zero
// - fixed code nine bits, high register bit zero is its top bit
// - fixed mode output is 0.245 V plus 5 mV per code
// - fixed code zero is off, output 0 V
// - fixed mode ignores processor target packets and power state commands
// - fixed mode ignores the host offset
// - leaving fixed mode returns to last processor target and power state
// - entering or leaving fixed mode ramps at quarter upward slew
module rtv_regs_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] page_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    // configuration storage defaults
    input wire logic [2:0] nvm_gain3,
    input wire logic [2:0] nvm_gain4,
    input wire logic [7:0] nvm_offset,
    // processor link
    input rtv_pkg::rtv_proc_cmd_t proc_cmd,
    input wire logic [15:0] up_slew_cyc,
    // analog status
    input wire logic vout_in_tol,
    // regulation loop
    output rtv_pkg::rtv_loop_t loop_out,
    output logic [2:0] gain3_code_r,
    output logic [2:0] gain4_code_r
);
    import rtv_pkg::*;

    typedef enum logic {
        RTV_SHIFT_IDLE,
        RTV_SHIFT_RAMP
    } rtv_shift_state_t;

    logic [7:0] offset_r;
    logic fix_en_r;
    logic [7:0] fix_lo_r;
    logic fix_hi_r;
    logic [8:0] fix_code_r;
    logic [8:0] tgt_code_r;
    logic off_r;
    logic jump_r;
    rtv_psi_t psi_r;
    rtv_psi_t psi_out_r;
    rtv_shift_state_t shift_state_r;
    rtv_shift_state_t shift_state_nxt;
    logic tol_meta_r;
    logic tol_sync_r;
    logic [17:0] step_cnt_r;
    logic [8:0] cur_code;
    logic ramp_busy;

    // register decode, only page 03h is ours
    wire page_ok = (page_sel == `RTV_PAGE_RAIL);
    wire wr_hit = reg_wr && page_ok;
    wire wr_gain3 = wr_hit && (reg_addr == `RTV_ADDR_GAIN3);
    wire wr_gain4 = wr_hit && (reg_addr == `RTV_ADDR_GAIN4);
    wire wr_offset = wr_hit && (reg_addr == `RTV_ADDR_OFFSET);
    wire wr_fix_en = wr_hit && (reg_addr == `RTV_ADDR_FIX_EN);
    wire wr_fix_lo = wr_hit && (reg_addr == `RTV_ADDR_FIX_LO);
    wire wr_fix_hi = wr_hit && (reg_addr == `RTV_ADDR_FIX_HI);

    // processor commands are dropped while fixed mode holds the rail
    wire tgt_take = proc_cmd.tgt_valid && !fix_en_r;
    wire off_take = proc_cmd.off_valid && !fix_en_r;
    wire psi_take = proc_cmd.psi_valid && !fix_en_r;

    // read mux, reserved bits come back zero
    wire [7:0] rd_mux =
        (reg_addr == `RTV_ADDR_GAIN3) ? {5'h00, gain3_code_r} :
        (reg_addr == `RTV_ADDR_GAIN4) ? {5'h00, gain4_code_r} :
        (reg_addr == `RTV_ADDR_OFFSET) ? offset_r :
        (reg_addr == `RTV_ADDR_FIX_EN) ? {7'h00, fix_en_r} :
        (reg_addr == `RTV_ADDR_FIX_LO) ? fix_lo_r :
        (reg_addr == `RTV_ADDR_FIX_HI) ? {7'h00, fix_hi_r} : 8'h00;

    // normal-mode goal: processor code plus signed offset, clamped to the code range
    // sum spans -128..638, so bit 9 means below zero for a negative offset, above 511 otherwise
    wire [9:0] offset_ext = {{2{offset_r[`RTV_OFFSET_SIGN_BIT]}}, offset_r};
    wire [9:0] norm_sum = {1'b0, tgt_code_r} + offset_ext;
    wire norm_neg = offset_r[`RTV_OFFSET_SIGN_BIT] && (norm_sum[9] || norm_sum == 10'h000);
    wire norm_big = !offset_r[`RTV_OFFSET_SIGN_BIT] && norm_sum[9];
    wire [8:0] norm_code = norm_neg ? `RTV_CODE_MIN : norm_big ? `RTV_CODE_MAX : norm_sum[8:0];

    // goal selection: fixed code wins, offset unused there, off forces zero
    wire [8:0] goal_code =
        fix_en_r ? fix_code_r :
        off_r ? `RTV_CODE_OFF : norm_code;

    // processor moves jump; offset and fixed-mode moves walk slowly
    wire ramp_jump = (tgt_take || off_take) && !wr_fix_en;

    // quarter of the upward slew, capped at the slowest allowed step time
    wire [17:0] quarter_cyc = {up_slew_cyc, 2'b00};
    wire [17:0] max_step_cyc = 18'(`RTV_MAX_STEP_CYC);
    wire [17:0] step_period = (quarter_cyc > max_step_cyc || quarter_cyc == 18'h00000) ? max_step_cyc : quarter_cyc;
    wire step_en = (step_cnt_r >= step_period - 18'h00001);

    // offset state machine wants the loop in full power until settled
    wire offset_start = wr_offset && !fix_en_r;
    wire offset_done = !ramp_busy && tol_sync_r;

    // gain registers; storage defaults are caught by the synchronous reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gain3_code_r <= nvm_gain3;
            gain4_code_r <= nvm_gain4;
        end else begin
            if (wr_gain3) begin
                gain3_code_r <= reg_wdata[`RTV_GAIN_MSB:0];
            end
            if (wr_gain4) begin
                gain4_code_r <= reg_wdata[`RTV_GAIN_MSB:0];
            end
        end
    end

    // offset and fixed-mode registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            offset_r <= nvm_offset;
            fix_en_r <= `RTV_RST_FIX_EN;
            fix_lo_r <= `RTV_RST_FIX_LO;
            fix_hi_r <= `RTV_RST_FIX_HI;
        end else begin
            if (wr_offset) begin
                offset_r <= reg_wdata;
            end
            if (wr_fix_en) begin
                fix_en_r <= reg_wdata[`RTV_FIX_EN_BIT];
            end
            if (wr_fix_lo) begin
                fix_lo_r <= reg_wdata;
            end
            if (wr_fix_hi) begin
                fix_hi_r <= reg_wdata[`RTV_FIX_HI_BIT];
            end
        end
    end

    // applied fixed code moves only on the high-byte write, so a low-then-high
    // pair never shows a mixed code; a lone low-byte write waits for the high byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fix_code_r <= {`RTV_RST_FIX_HI, `RTV_RST_FIX_LO};
        end else if (wr_fix_hi) begin
            fix_code_r <= {reg_wdata[`RTV_FIX_HI_BIT], fix_lo_r};
        end
    end

    // last processor target and power state, kept across fixed mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tgt_code_r <= `RTV_CODE_OFF;
            off_r <= 1'b1;
            psi_r <= RTV_PS_FULL;
        end else begin
            if (tgt_take) begin
                tgt_code_r <= proc_cmd.tgt_code;
                off_r <= 1'b0;
            end else if (off_take) begin
                off_r <= 1'b1;
            end
            if (psi_take) begin
                psi_r <= proc_cmd.psi;
            end
        end
    end

    // read data register, answers one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= page_ok ? rd_mux : 8'h00;
        end
    end

    // tolerance comes from the analog side, two flops before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tol_meta_r <= 1'b0;
            tol_sync_r <= 1'b0;
        end else begin
            tol_meta_r <= vout_in_tol;
            tol_sync_r <= tol_meta_r;
        end
    end

    // slew divider; a slow step also restarts on any jump
    always_ff @(posedge sys_clk) begin
        if (rst || step_en || ramp_jump) begin
            step_cnt_r <= 18'h00000;
        end else begin
            step_cnt_r <= step_cnt_r + 18'h00001;
        end
    end

    // offset ramp tracking: a processor power command ends the forced state
    always_comb begin
        shift_state_nxt = shift_state_r;
        unique case (shift_state_r)
            RTV_SHIFT_IDLE: begin
                if (offset_start) begin
                    shift_state_nxt = RTV_SHIFT_RAMP;
                end
            end
            RTV_SHIFT_RAMP: begin
                if (psi_take || fix_en_r) begin
                    shift_state_nxt = RTV_SHIFT_IDLE;
                end else if (offset_done && !offset_start) begin
                    shift_state_nxt = RTV_SHIFT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_state_r <= RTV_SHIFT_IDLE;
        end else begin
            shift_state_r <= shift_state_nxt;
        end
    end

    // processor jump waits one cycle so the goal already holds the new code
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            jump_r <= 1'b0;
        end else begin
            jump_r <= ramp_jump;
        end
    end

    // power state shown to the loop, registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            psi_out_r <= RTV_PS_FULL;
        end else begin
            psi_out_r <= (shift_state_r == RTV_SHIFT_RAMP) ? RTV_PS_FULL : psi_r;
        end
    end

    rtv_ramp u_ramp (
        .sys_clk(sys_clk),
        .rst(rst),
        .goal(goal_code),
        .jump(jump_r),
        .step_en(step_en),
        .cur_r(cur_code),
        .busy(ramp_busy)
    );

    // loop outputs; code zero is off, any other code is 0.245 V plus 5 mV per step
    assign loop_out.target_code = cur_code;
    assign loop_out.target_off = (cur_code == `RTV_CODE_OFF);
    assign loop_out.psi = psi_out_r;
    assign loop_out.ramping = ramp_busy;
    assign loop_out.fixed_active = fix_en_r;

    // checks next to the logic
    a_page_gate_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        (reg_wr && !page_ok) |=> $stable(offset_r) && $stable(fix_en_r) && $stable(gain3_code_r))
        else $error("write outside page changed a register");

    a_rsvd_read_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        (reg_rd && page_ok && reg_addr == `RTV_ADDR_GAIN4) |=> (reg_rdata_r[7:3] == 5'h00)
            && (reg_rdata_r[2:0] == gain4_code_r))
        else $error("gain readback wrong or reserved bits set");

    a_gain_write_low: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_gain3 |=> (gain3_code_r == $past(reg_wdata[2:0])))
        else $error("gain write not stored");

    a_offset_full_power: assert property (
        @(posedge sys_clk) disable iff (rst)
        (offset_start && !psi_take) |=> (shift_state_r == RTV_SHIFT_RAMP) ##1 (psi_out_r == RTV_PS_FULL))
        else $error("offset write did not force full power");

    a_offset_state_restore: assert property (
        @(posedge sys_clk) disable iff (rst)
        (shift_state_r == RTV_SHIFT_RAMP && offset_done && !offset_start && !psi_take && !fix_en_r)
            |=> (shift_state_r == RTV_SHIFT_IDLE) ##1 (psi_out_r == $past(psi_r, 2)))
        else $error("power state not restored after offset ramp");

    a_psi_obeyed: assert property (
        @(posedge sys_clk) disable iff (rst)
        (psi_take && !offset_start) |-> ##2 (psi_out_r == $past(proc_cmd.psi, 2)))
        else $error("processor power state not obeyed");

    a_off_zero_goal: assert property (
        @(posedge sys_clk) disable iff (rst)
        (off_r && !fix_en_r) |-> (goal_code == `RTV_CODE_OFF))
        else $error("off command left a nonzero goal");

    a_fix_ignores_proc: assert property (
        @(posedge sys_clk) disable iff (rst)
        fix_en_r |=> $stable(tgt_code_r) && $stable(psi_r) && $stable(off_r))
        else $error("processor command taken in fixed mode");

    a_fix_goal_code: assert property (
        @(posedge sys_clk) disable iff (rst)
        fix_en_r |-> (goal_code == fix_code_r))
        else $error("fixed mode goal not the fixed code");

    a_fix_code_whole: assert property (
        @(posedge sys_clk) disable iff (rst)
        $changed(fix_code_r) |-> $past(wr_fix_hi))
        else $error("fixed code changed without high byte write");

    a_ramp_one_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!$past(jump_r) && $changed(cur_code)) |-> $past(step_en)
            && ((cur_code == $past(cur_code) + 9'h001) || (cur_code == $past(cur_code) - 9'h001)))
        else $error("slow ramp moved more than one code");

    a_step_period_cap: assert property (
        @(posedge sys_clk) disable iff (rst)
        step_cnt_r < max_step_cyc)
        else $error("slew step slower than the minimum rate");
endmodule

//--- tb/rtv_proc_model.sv
// Purpose: processor voltage link and output tolerance stand-in for the rail target block
// Assumes: commands launched just after a rising sys_clk, valid bits one cycle wide
// Notes: tolerance is moved by the bench so a ramp can be held out of tolerance
`timescale 1ns/1ns
module rtv_proc_model (
    // clock
    input wire logic sys_clk,
    // toward the block
    output rtv_pkg::rtv_proc_cmd_t proc_cmd,
    output logic vout_in_tol
);
    import rtv_pkg::*;

    // idle link, output not yet settled
    initial begin
        proc_cmd = '0;
        vout_in_tol = 1'b0;
    end

    // one command; code clamped into the usable output range
    task automatic send(input logic vv, input logic [8:0] code, input logic ov, input logic pv, input rtv_psi_t ps);
        @(posedge sys_clk);
        proc_cmd <= '{vv, (code == 9'h000) ? 9'h001 : code, ov, pv, ps};
        @(posedge sys_clk);
        proc_cmd <= '{1'b0, proc_cmd.tgt_code, 1'b0, 1'b0, proc_cmd.psi};
    endtask

    // tolerance flag, taken at an edge like any other input
    task automatic set_tol(input logic b);
        @(posedge sys_clk);
        vout_in_tol <= b;
    endtask
endmodule

//--- tb/rtv_regs_top_bench.sv
// Purpose: self-checking bench of the rail target registers
// Assumes: up_slew_cyc of 2 gives an 8-cycle step period
// Notes: config defaults gain3 5, gain4 2, offset 1 so reset loading is visible
`timescale 1ns/1ns
`include "rtv_regs.svh"
module rtv_regs_top_bench;
    import rtv_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] page_sel = 8'h03;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] up_slew = 16'h0002;
    logic [7:0] reg_rdata_r;
    logic [2:0] gain3_code_r;
    logic [2:0] gain4_code_r;
    logic vout_in_tol;
    rtv_proc_cmd_t proc_cmd;
    rtv_loop_t loop_out;
    int n_mismatch = 0;
    int tests_run = 0;
    int gap;

    // free running 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    rtv_regs_top dut_u (.sys_clk(sys_clk), .rst(rst), .page_sel(page_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .nvm_gain3(3'h5),
        .nvm_gain4(3'h2), .nvm_offset(8'h01), .proc_cmd(proc_cmd), .up_slew_cyc(up_slew),
        .vout_in_tol(vout_in_tol), .loop_out(loop_out), .gain3_code_r(gain3_code_r), .gain4_code_r(gain4_code_r));

    rtv_proc_model proc_u (.sys_clk(sys_clk), .proc_cmd(proc_cmd), .vout_in_tol(vout_in_tol));

    // verdict in one place only
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // let n edges land, then look just after them
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle strobes, held until the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, 16'(reg_rdata_r), 16'(exp));
    endtask

    // bounded wait for a target; running out ends the run
    task automatic wait_code(input logic [8:0] exp);
        for (int i = 0; i < 3000 && loop_out.target_code !== exp; i++) cyc(1);
        chk("target_code", 16'(loop_out.target_code), 16'(exp));
        chk("ramping", 16'(loop_out.ramping), 16'h0000);
        if (loop_out.target_code !== exp) tally_and_finish();
    endtask

    // cycles between two successive ramp steps
    task automatic step_gap(input int exp);
        logic [8:0] v;
        v = loop_out.target_code;
        for (int i = 0; i < 600 && loop_out.target_code === v; i++) cyc(1);
        v = loop_out.target_code;
        for (gap = 0; gap < 600 && loop_out.target_code === v; gap++) cyc(1);
        chk("step_gap", 16'(gap), 16'(exp));
        chk("ramping", 16'(loop_out.ramping), 16'h0001);
    endtask

    task automatic t_reset();
        chk("target_off", 16'(loop_out.target_off), 16'h0001);
        rd_chk("gain3", `RTV_ADDR_GAIN3, 8'h05);
        rd_chk("gain4", `RTV_ADDR_GAIN4, 8'h02);
        rd_chk("offset", `RTV_ADDR_OFFSET, 8'h01);
        rd_chk("fix_en", `RTV_ADDR_FIX_EN, 8'h00);
        rd_chk("fix_lo", `RTV_ADDR_FIX_LO, 8'h83);
        rd_chk("fix_hi", `RTV_ADDR_FIX_HI, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_gains();
        for (int c = 0; c < 8; c++) begin
            wr(`RTV_ADDR_GAIN3, 8'hf8 | 8'(c));
            wr(`RTV_ADDR_GAIN4, 8'hff ^ 8'(c));
            rd_chk("gain3", `RTV_ADDR_GAIN3, 8'(c));
            rd_chk("gain4", `RTV_ADDR_GAIN4, 8'(7 - c));
            chk("gain3_code", 16'(gain3_code_r), 16'(c));
            chk("gain4_code", 16'(gain4_code_r), 16'(7 - c));
        end
        @(posedge sys_clk);
        page_sel <= 8'h04;
        wr(`RTV_ADDR_GAIN3, 8'h00);
        page_sel <= 8'h03;
        rd_chk("gain3", `RTV_ADDR_GAIN3, 8'h07);
        rd_chk("unmapped", 8'h90, 8'h00);
        $display("test gains done");
    endtask

    task automatic t_offset();
        proc_u.send(1'b1, 9'd100, 1'b0, 1'b0, RTV_PS_FULL);
        cyc(2);
        chk("target", 16'(loop_out.target_code), 16'd101);
        proc_u.send(1'b0, 9'd0, 1'b0, 1'b1, RTV_PS_ONE);
        cyc(2);
        wr(`RTV_ADDR_OFFSET, 8'h05);
        cyc(2);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_FULL));
        step_gap(8);
        wait_code(9'd105);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_FULL));
        proc_u.set_tol(1'b1);
        cyc(6);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_ONE));
        proc_u.send(1'b0, 9'd0, 1'b0, 1'b1, RTV_PS_TWO);
        cyc(2);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_TWO));
        chk("target", 16'(loop_out.target_code), 16'd105);
        $display("test offset done");
    endtask

    task automatic t_fixed();
        wr(`RTV_ADDR_FIX_LO, 8'h10);
        wr(`RTV_ADDR_FIX_EN, 8'hff);
        rd_chk("fix_en", `RTV_ADDR_FIX_EN, 8'h01);
        chk("fixed_active", 16'(loop_out.fixed_active), 16'h0001);
        step_gap(8);
        proc_u.send(1'b1, 9'd50, 1'b0, 1'b0, RTV_PS_FULL);
        proc_u.send(1'b0, 9'd0, 1'b0, 1'b1, RTV_PS_THREE);
        wait_code(9'd131);
        wr(`RTV_ADDR_FIX_LO, 8'h84);
        cyc(20);
        chk("target", 16'(loop_out.target_code), 16'd131);
        wr(`RTV_ADDR_FIX_HI, 8'hfe);
        rd_chk("fix_hi", `RTV_ADDR_FIX_HI, 8'h00);
        wait_code(9'd132);
        wr(`RTV_ADDR_FIX_LO, 8'h00);
        wr(`RTV_ADDR_FIX_HI, 8'h00);
        wait_code(9'd0);
        chk("target_off", 16'(loop_out.target_off), 16'h0001);
        wr(`RTV_ADDR_FIX_HI, 8'h01);
        wait_code(9'd256);
        $display("test fixed done");
    endtask

    task automatic t_exit();
        wr(`RTV_ADDR_FIX_EN, 8'h00);
        wait_code(9'd105);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_TWO));
        // slow processor slew so the quarter rate would pass the 250-cycle cap
        @(posedge sys_clk);
        up_slew <= 16'h0100;
        wr(`RTV_ADDR_OFFSET, 8'hff);
        step_gap(250);
        chk("psi", 16'(loop_out.psi), 16'(RTV_PS_FULL));
        wait_code(9'd99);
        proc_u.send(1'b0, 9'd0, 1'b1, 1'b0, RTV_PS_FULL);
        cyc(2);
        chk("target", 16'(loop_out.target_code), 16'd0);
        chk("target_off", 16'(loop_out.target_off), 16'h0001);
        $display("test exit done");
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_gains();
        t_offset();
        t_fixed();
        t_exit();
        tally_and_finish();
    end
endmodule
